// ===== core/rtc_top.sv
/*
  Calendar clock with two alarms, countdown stopwatch, periodic tick
  events, interrupt and wake-up outputs, reached over a plain register
  port. Assumes a single 200 MHz clock; the crystal arrives as a level
  sampled by that clock and is used only through an enable pulse.
*/
// The address map and the strobed register port were chosen for this implementation.
// Behaviour
// - Timekeeping advances only from the 32.768 kHz crystal, apart from system timing.
// - Prescaler divides crystal edges down to one tick per second.
// - Seconds and minutes count modulo 60; minutes step when seconds wrap.
// - Hours count modulo 24, days over 32768; each steps on lower wrap.
// - Second, minute, hour and day ticks each raise a maskable interrupt.
// - Enabled alarm raises an interrupt when counters equal the alarm value.
// - First alarm compares time of day only, firing daily.
// - Second alarm compares day and time of day, firing once.
// - Stopwatch decrements from a loaded value on each second tick.
// - Enabled stopwatch raises an interrupt on underflow.
// - Any wake-up event asserts the wake output to the processor.
// - Same wake event also restarts the regulator from hibernate.
module rtc_top #(
  parameter int PRESCALE_DIV = rtc_pkg::PRESCALE_DIV
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  input  wire logic                       xtal_in,
  input  wire logic [rtc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [rtc_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [rtc_pkg::DATA_W-1:0] rdata_out,
  output logic                            irq_out,
  output logic                            wake_out,
  output logic                            regulator_wake_out
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              tick;
  logic              tick_q_r;
  logic              time_wr;
  logic              alarm_wr;
  logic              sw_wr;
  logic              ctrl_wr;
  logic              status_wr;
  logic              mask_wr;
  logic              step;
  logic [SEC_W-1:0]  sec;
  logic [MIN_W-1:0]  min;
  logic [HOUR_W-1:0] hour;
  logic [DAY_W-1:0]  day;
  logic              sec_wrap;
  logic              min_wrap;
  logic              hour_wrap;
  logic              day_wrap;
  logic [31:0]       alarm_r;
  logic [SW_W-1:0]   sw_cnt_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [EV_W-1:0]   status_r;
  logic [EV_W-1:0]   status_nxt;
  logic [EV_W-1:0]   mask_r;
  logic [EV_W-1:0]   events;
  logic              tod_match;
  logic              day_match;
  logic              sw_under;
  logic [31:0]       time_word;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  // Strobes are single-cycle, so each write is a plain one-cycle qualifier
  assign time_wr   = wr_in && (addr_in == OFF_TIME);
  assign alarm_wr  = wr_in && (addr_in == OFF_ALARM);
  assign sw_wr     = wr_in && (addr_in == OFF_STOPWATCH);
  assign ctrl_wr   = wr_in && (addr_in == OFF_CTRL);
  assign status_wr = wr_in && (addr_in == OFF_STATUS);
  assign mask_wr   = wr_in && (addr_in == OFF_MASK);

  // ----------------------------------------------------------------
  // Second tick
  // ----------------------------------------------------------------
  // Crystal edges are the only time base; the system clock just samples
  rtc_prescaler #(
    .DIV      (PRESCALE_DIV)
  ) u_prescaler (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .xtal_in  (xtal_in),
    .clear_in (time_wr),
    .tick_out (tick)
  );

  // A time load restarts the second so the new value lasts a full second
  assign step = tick && !time_wr;

  // Delayed tick marks the cycle in which counters hold their new value
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) tick_q_r <= 1'b0;
    else        tick_q_r <= step;
  end

  // ----------------------------------------------------------------
  // Cascaded calendar counters
  // ----------------------------------------------------------------
  // Seconds modulo 60
  rtc_wrap_counter #(
    .W           (SEC_W),
    .MAX         (SEC_MAX)
  ) u_sec (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .step_in     (step),
    .load_in     (time_wr),
    .load_val_in (wdata_in[SEC_LSB +: SEC_W]),
    .count_out   (sec),
    .wrap_out    (sec_wrap)
  );

  // Minutes modulo 60, stepped by the seconds carry
  rtc_wrap_counter #(
    .W           (MIN_W),
    .MAX         (MIN_MAX)
  ) u_min (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .step_in     (sec_wrap),
    .load_in     (time_wr),
    .load_val_in (wdata_in[MIN_LSB +: MIN_W]),
    .count_out   (min),
    .wrap_out    (min_wrap)
  );

  // Hours modulo 24, stepped by the minutes carry
  rtc_wrap_counter #(
    .W           (HOUR_W),
    .MAX         (HOUR_MAX)
  ) u_hour (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .step_in     (min_wrap),
    .load_in     (time_wr),
    .load_val_in (wdata_in[HOUR_LSB +: HOUR_W]),
    .count_out   (hour),
    .wrap_out    (hour_wrap)
  );

  // Days over the full 15-bit range, wrapping to zero
  rtc_wrap_counter #(
    .W           (DAY_W),
    .MAX         (DAY_MAX)
  ) u_day (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .step_in     (hour_wrap),
    .load_in     (time_wr),
    .load_val_in (wdata_in[DAY_LSB +: DAY_W]),
    .count_out   (day),
    .wrap_out    (day_wrap)
  );

  assign time_word = {day, hour, min, sec};

  // ----------------------------------------------------------------
  // Alarms
  // ----------------------------------------------------------------
  // Alarm value register, cleared at reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in)        alarm_r <= ALARM_RST;
    else if (alarm_wr) alarm_r <= wdata_in;
  end

  // Time-of-day compare ignores the day field, so it repeats daily
  assign tod_match = (sec  == alarm_r[SEC_LSB  +: SEC_W])
                  && (min  == alarm_r[MIN_LSB  +: MIN_W])
                  && (hour == alarm_r[HOUR_LSB +: HOUR_W]);
  // Full compare adds the day, so it fires on one date only
  assign day_match = tod_match && (day == alarm_r[DAY_LSB +: DAY_W]);

  // ----------------------------------------------------------------
  // Stopwatch
  // ----------------------------------------------------------------
  // Underflow is a tick that finds the count already at zero
  assign sw_under = step && ctrl_r[CTRL_SW] && (sw_cnt_r == '0);

  // Count down once per second while enabled; holds at zero after
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in)                               sw_cnt_r <= SW_RST;
    else if (sw_wr)                           sw_cnt_r <= wdata_in[SW_W-1:0];
    else if (step && ctrl_r[CTRL_SW] && !sw_under) sw_cnt_r <= sw_cnt_r - 1'b1;
  end

  // Stopwatch enable drops itself on underflow so the event fires once
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr)  ctrl_nxt = wdata_in[CTRL_W-1:0];
    if (sw_under) ctrl_nxt[CTRL_SW] = 1'b0;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) ctrl_r <= CTRL_RST;
    else        ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------------------------------
  // Events, status and mask
  // ----------------------------------------------------------------
  // Second tick is the step itself; the other periodic ticks come straight from the counter carries
  assign events[EV_SEC]  = step;
  assign events[EV_MIN]  = sec_wrap;
  assign events[EV_HOUR] = min_wrap;
  assign events[EV_DAY]  = hour_wrap;
  // Alarms are checked once, in the cycle after the counters move
  assign events[EV_A1]   = tick_q_r && ctrl_r[CTRL_A1] && tod_match;
  assign events[EV_A2]   = tick_q_r && ctrl_r[CTRL_A2] && day_match;
  assign events[EV_SW]   = sw_under;

  // Sticky bits, write one to clear; a new event beats the clear
  assign status_nxt = (status_r & ~(status_wr ? wdata_in[EV_W-1:0] : '0)) | events;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) status_r <= '0;
    else        status_r <= status_nxt;
  end

  // Per-event enable onto the interrupt line
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in)       mask_r <= MASK_RST;
    else if (mask_wr) mask_r <= wdata_in[EV_W-1:0];
  end

  // ----------------------------------------------------------------
  // Outputs toward the processor
  // ----------------------------------------------------------------
  // Level interrupt while an unmasked flag is pending
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) irq_out <= 1'b0;
    else        irq_out <= |(status_nxt & mask_r);
  end

  // Wake stays high until software clears all flags; the processor's
  // own wake-enable decides whether it acts on it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) wake_out <= 1'b0;
    else        wake_out <= |status_nxt;
  end

  // Regulator wake mirrors the processor wake; a level suits a
  // regulator that may take many cycles to come up
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) regulator_wake_out <= 1'b0;
    else        regulator_wake_out <= |status_nxt;
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  // Unmapped offsets and idle cycles read as zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        OFF_TIME:      rdata_out <= time_word;
        OFF_ALARM:     rdata_out <= alarm_r;
        OFF_STOPWATCH: rdata_out <= {{(DATA_W-SW_W){1'b0}}, sw_cnt_r};
        OFF_CTRL:      rdata_out <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
        OFF_STATUS:    rdata_out <= {{(DATA_W-EV_W){1'b0}}, status_r};
        OFF_MASK:      rdata_out <= {{(DATA_W-EV_W){1'b0}}, mask_r};
        default:       rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Last second of a minute followed by the roll-over
  sequence s_sec_last;
    step && sec == SEC_MAX && !time_wr;
  endsequence
  sequence s_min_roll;
    sec == '0 && min == ((($past(min) == MIN_MAX)) ? '0 : $past(min) + 1'b1);
  endsequence

  a_sec_count_up: assert property (step && sec != SEC_MAX |=> sec == $past(sec) + 1'b1)
    else $error("seconds did not advance");

  a_min_roll_over: assert property (s_sec_last |=> s_min_roll)
    else $error("minute did not follow seconds wrap");

  a_hour_wrap_zero: assert property (s_sec_last ##0 (min == MIN_MAX && hour == HOUR_MAX)
    |=> hour == '0 && day == $past(day) + 1'b1)
    else $error("hour did not wrap to zero");

  a_day_wrap_zero: assert property (hour_wrap && day == DAY_MAX |=> day == '0)
    else $error("day did not wrap to zero");

  a_time_steady: assert property (!step && !time_wr |=> $stable(time_word))
    else $error("time moved without a tick");

  a_alarm1_daily: assert property (tick_q_r && ctrl_r[CTRL_A1] && tod_match
    |=> status_r[EV_A1] && (irq_out || !$past(mask_r[EV_A1])))
    else $error("time-of-day alarm missed");

  // Whole-word compare stands apart from the field-wise match logic
  a_alarm2_date: assert property (tick_q_r && ctrl_r[CTRL_A2] && time_word == alarm_r |=> status_r[EV_A2])
    else $error("date alarm missed");

  a_alarm2_wrong_day: assert property (tick_q_r && time_word != alarm_r |-> !events[EV_A2])
    else $error("date alarm fired on wrong day");

  a_sw_decrement: assert property (step && ctrl_r[CTRL_SW] && sw_cnt_r != '0 && !sw_wr
    |=> sw_cnt_r == $past(sw_cnt_r) - 1'b1)
    else $error("stopwatch did not count down");

  a_sw_underflow: assert property (sw_under && !sw_wr
    |=> status_r[EV_SW] && !ctrl_r[CTRL_SW] && sw_cnt_r == '0)
    else $error("stopwatch underflow not flagged");

  a_flag_sticky: assert property (status_r[EV_SEC] && !status_wr
    |=> status_r[EV_SEC] [*1] ##0 wake_out)
    else $error("flag cleared without software");

  a_wake_follow: assert property (|events |=> wake_out && regulator_wake_out)
    else $error("wake not raised after event");

  a_tick_events: assert property (min_wrap |=> status_r[EV_HOUR] && status_r[EV_MIN] && status_r[EV_SEC])
    else $error("carry ticks not flagged");

  a_irq_masked: assert property (mask_r == '0 |=> !irq_out)
    else $error("interrupt raised while all masked");

  a_wake_idle: assert property (status_r == '0 && events == '0 |=> !wake_out && !regulator_wake_out)
    else $error("wake raised with no pending flag");
endmodule

// ===== pkg/rtc_pkg.sv
/*
  Shared constants of the calendar clock: register offsets, field layout
  of the time and alarm words, reset values, event bit positions and the
  prescaler ratio. Assumes a 32-bit register port with byte offsets.
*/
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and offsets
  // ----------------------------------------------------------------
  localparam int             ADDR_W        = 8;
  localparam int             DATA_W        = 32;
  localparam logic [7:0]     OFF_TIME      = 8'h00;
  localparam logic [7:0]     OFF_ALARM     = 8'h04;
  localparam logic [7:0]     OFF_STOPWATCH = 8'h08;
  localparam logic [7:0]     OFF_CTRL      = 8'h0C;
  localparam logic [7:0]     OFF_STATUS    = 8'h10;
  localparam logic [7:0]     OFF_MASK      = 8'h14;

  // ----------------------------------------------------------------
  // Time word layout (also used by the alarm word)
  // ----------------------------------------------------------------
  localparam int             SEC_LSB       = 0;
  localparam int             SEC_W         = 6;
  localparam int             MIN_LSB       = 6;
  localparam int             MIN_W         = 6;
  localparam int             HOUR_LSB      = 12;
  localparam int             HOUR_W        = 5;
  localparam int             DAY_LSB       = 17;
  localparam int             DAY_W         = 15;
  localparam logic [5:0]     SEC_MAX       = 6'h3B;
  localparam logic [5:0]     MIN_MAX       = 6'h3B;
  localparam logic [4:0]     HOUR_MAX      = 5'h17;
  localparam logic [14:0]    DAY_MAX       = 15'h7FFF;
  localparam int             SW_W          = 16;

  // ----------------------------------------------------------------
  // Control and event bits
  // ----------------------------------------------------------------
  localparam int             CTRL_A1       = 0;
  localparam int             CTRL_A2       = 1;
  localparam int             CTRL_SW       = 2;
  localparam int             CTRL_W        = 3;
  localparam int             EV_SEC        = 0;
  localparam int             EV_MIN        = 1;
  localparam int             EV_HOUR       = 2;
  localparam int             EV_DAY        = 3;
  localparam int             EV_A1         = 4;
  localparam int             EV_A2         = 5;
  localparam int             EV_SW         = 6;
  localparam int             EV_W          = 7;

  // ----------------------------------------------------------------
  // Reset values and prescaler ratio
  // ----------------------------------------------------------------
  localparam logic [31:0]    ALARM_RST     = 32'h0000_0000;
  localparam logic [15:0]    SW_RST        = 16'h0000;
  localparam logic [2:0]     CTRL_RST      = 3'h0;
  localparam logic [6:0]     MASK_RST      = 7'h00;
  localparam int             XTAL_HZ       = 32'h0000_8000;
  localparam int             TICK_HZ       = 32'h0000_0001;
  localparam int             PRESCALE_DIV  = XTAL_HZ / TICK_HZ;
  localparam int             PRE_W         = 16;

endpackage

// ===== core/rtc_prescaler.sv
/*
  Crystal edge detector and prescaler: counts rising edges of the sampled
  crystal input and emits a one-cycle tick every DIV edges.
  Assumes the crystal level is already synchronous to clock_in.
*/
module rtc_prescaler #(
  parameter int DIV = rtc_pkg::PRESCALE_DIV
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic xtal_in,
  input  wire logic clear_in,
  output logic      tick_out
);
  import rtc_pkg::*;

  logic             xtal_r;
  logic [PRE_W-1:0] pre_cnt_r;
  logic             rise;

  // Crystal edge turns into a one-cycle enable
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) xtal_r <= 1'b0;
    else        xtal_r <= xtal_in;
  end
  assign rise = xtal_in & ~xtal_r;

  // Divide crystal edges down to the one second tick
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_r <= '0;
      tick_out  <= 1'b0;
    end else if (clear_in) begin
      pre_cnt_r <= '0;
      tick_out  <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (rise) begin
        if (pre_cnt_r == PRE_W'(DIV - 1)) begin
          pre_cnt_r <= '0;
          tick_out  <= 1'b1;
        end else begin
          pre_cnt_r <= pre_cnt_r + 1'b1;
        end
      end
    end
  end

  // Tick only follows the last edge of a full division
  a_prescale_tick: assert property (@(posedge clock_in) disable iff (rst_in)
    tick_out |-> $past(pre_cnt_r) == PRE_W'(DIV - 1) && pre_cnt_r == '0)
    else $error("tick without full prescaler period");
endmodule

// ===== core/rtc_wrap_counter.sv
/*
  Loadable modulo counter used for seconds, minutes, hours and days.
  Assumes step and load are never meant to act together; load wins.
*/
module rtc_wrap_counter #(
  parameter int          W   = 6,
  parameter logic [W-1:0] MAX = '1
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic         step_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  output logic      [W-1:0] count_out,
  output logic              wrap_out
);
  // Count up, wrap to zero after MAX, zero at reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in)                    count_out <= '0;
    else if (load_in)              count_out <= load_val_in;
    else if (step_in && wrap_out)  count_out <= '0;
    else if (step_in)              count_out <= count_out + 1'b1;
  end

  // Carry toward the next counter up
  assign wrap_out = step_in && !load_in && (count_out == MAX);
endmodule

// ===== sim/proc_wake_model.sv
/*
  Processor-side wake logic facing the calendar clock: a wake-enable
  register and the gating of the block's wake and regulator events.
  Assumes the bench writes the enable bit and samples the outputs.
*/
module proc_wake_model (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic wake_in,
  input  wire logic regulator_wake_in,
  input  wire logic wake_enable_in,
  output logic      core_wake_out,
  output logic      regulator_on_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic system_wake_enable_reg;

  // Enable bit, loaded like a software register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      system_wake_enable_reg <= 1'b0;
    end else begin
      system_wake_enable_reg <= wake_enable_in;
    end
  end

  // Events count as wake sources only while enabled; no latching here
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      core_wake_out    <= 1'b0;
      regulator_on_out <= 1'b0;
    end else begin
      core_wake_out    <= wake_in & system_wake_enable_reg;
      regulator_on_out <= regulator_wake_in & system_wake_enable_reg;
    end
  end
endmodule

// ===== sim/calendar_rtc_alarm_stopwatch_tb_top.sv
/*
  Self-checking bench of the calendar clock: register port, counting,
  alarms, stopwatch, interrupt and wake paths.
  Assumes rtc_pkg is compiled first and a short prescaler ratio.
*/
module calendar_rtc_alarm_stopwatch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;

  localparam int DIV = 4;

  logic              clock_in  = 1'b0;
  logic              rst_in    = 1'b1;
  logic              xtal_in   = 1'b0;
  logic              wr_in     = 1'b0;
  logic              rd_in     = 1'b0;
  logic              wake_en   = 1'b0;
  logic [ADDR_W-1:0] addr_in   = '0;
  logic [DATA_W-1:0] wdata_in  = '0;
  logic [DATA_W-1:0] rdata_out;
  logic              irq_out;
  logic              wake_out;
  logic              regulator_wake_out;
  logic              core_wake;
  logic              regulator_on;
  int                failures        = 0;
  int                samples_checked = 0;

  rtc_top #(.PRESCALE_DIV(DIV)) rtc_top_inst (
    .clock_in(clock_in), .rst_in(rst_in), .xtal_in(xtal_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .wake_out(wake_out), .regulator_wake_out(regulator_wake_out));

  proc_wake_model proc_wake_model_inst (
    .clock_in(clock_in), .rst_in(rst_in), .wake_in(wake_out),
    .regulator_wake_in(regulator_wake_out), .wake_enable_in(wake_en),
    .core_wake_out(core_wake), .regulator_on_out(regulator_on));

  // 200 MHz system clock
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One-cycle write; the trailing edge keeps back-to-back calls legal
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    chk(rdata_out, exp, what);
  endtask

  // Crystal rising edges, each level held well beyond two clocks
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clock_in);
      xtal_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      xtal_in <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
    repeat (6) @(posedge clock_in);
  endtask

  // Lets registered levels follow a status change
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] offs [7];
    offs = '{OFF_TIME, OFF_ALARM, OFF_STOPWATCH, OFF_CTRL, OFF_STATUS, OFF_MASK, 8'h18};
    for (int i = 0; i < 7; i++) begin
      rd_chk(offs[i], 32'h0000_0000, "reset value");
    end
    chk({29'h0, irq_out, wake_out, regulator_wake_out}, 32'h0, "outputs after reset");
    $display("test reset done");
  endtask

  task automatic t_count();
    wr(OFF_TIME, {15'h0000, 5'h00, 6'h00, SEC_MAX});
    edges(DIV - 1);
    rd_chk(OFF_TIME, {15'h0000, 5'h00, 6'h00, SEC_MAX}, "no tick early");
    edges(1);
    rd_chk(OFF_TIME, 32'h0000_0040, "minute carry");
    rd_chk(OFF_STATUS, 32'h0000_0003, "sec and min events");
    wr(OFF_STATUS, 32'h0000_00FF);
    wr(OFF_TIME, {DAY_MAX, HOUR_MAX, MIN_MAX, SEC_MAX});
    edges(DIV);
    rd_chk(OFF_TIME, 32'h0000_0000, "full wrap");
    rd_chk(OFF_STATUS, 32'h0000_000F, "all tick events");
    $display("test count done");
  endtask

  task automatic t_irq();
    settle();
    chk({31'h0, irq_out}, 32'h0, "masked irq");
    chk({31'h0, wake_out}, 32'h1, "wake ignores mask");
    chk({31'h0, regulator_wake_out}, 32'h1, "regulator wake");
    chk({30'h0, core_wake, regulator_on}, 32'h0, "wake not enabled");
    wake_en <= 1'b1;
    wr(OFF_MASK, 32'h0000_0001);
    settle();
    chk({31'h0, irq_out}, 32'h1, "unmasked irq");
    chk({30'h0, core_wake, regulator_on}, 32'h3, "wake enabled");
    rd_chk(OFF_MASK, 32'h0000_0001, "mask readback");
    wr(OFF_STATUS, 32'h0000_0001);
    settle();
    chk({31'h0, irq_out}, 32'h0, "irq after clear");
    rd_chk(OFF_STATUS, 32'h0000_000E, "others stay set");
    wr(OFF_STATUS, 32'h0000_000E);
    settle();
    chk({30'h0, wake_out, regulator_wake_out}, 32'h0, "wake after clear");
    wr(OFF_MASK, 32'h0000_0000);
    $display("test irq done");
  endtask

  task automatic t_alarm();
    wr(OFF_ALARM, 32'h0004_0006);
    wr(OFF_CTRL, 32'h0000_0003);
    wr(OFF_TIME, 32'h0006_0005);
    edges(DIV);
    rd_chk(OFF_STATUS, 32'h0000_0011, "time of day alarm only");
    wr(OFF_STATUS, 32'h0000_00FF);
    wr(OFF_TIME, 32'h0004_0005);
    edges(DIV);
    rd_chk(OFF_STATUS, 32'h0000_0031, "day and time alarm");
    wr(OFF_STATUS, 32'h0000_00FF);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_TIME, 32'h0004_0005);
    edges(DIV);
    rd_chk(OFF_STATUS, 32'h0000_0001, "alarms disabled");
    $display("test alarm done");
  endtask

  task automatic t_stopwatch();
    wr(OFF_STATUS, 32'h0000_00FF);
    wr(OFF_STOPWATCH, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0004);
    wr(OFF_TIME, 32'h0000_0000);
    edges(DIV);
    rd_chk(OFF_STOPWATCH, 32'h0000_0000, "countdown step");
    rd_chk(OFF_STATUS, 32'h0000_0001, "no underflow yet");
    edges(DIV);
    rd_chk(OFF_STATUS, 32'h0000_0041, "underflow event");
    rd_chk(OFF_CTRL, 32'h0000_0000, "enable self-clears");
    $display("test stopwatch done");
  endtask

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_count();
    t_irq();
    t_alarm();
    t_stopwatch();
    end_of_test();
  end

  // Scenarios need a few hundred cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge clock_in);
    failures++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
